// ---- common/ccbp_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface ccbp_if;
    // controller to device
    logic rd_grant_b;
    logic wr_grant_b;
    logic rd_ready_b;
    logic wr_ready_b;
    logic retry_b;
    logic mem_exc_b;
    logic we_permit_b;
    logic test_b;
    logic wr_cc;
    logic wr_cc_oe_b;
    // device to controller, each with its enable except exec_strobe
    logic [1:0] size;
    logic size_oe_b;
    logic priv;
    logic priv_oe_b;
    logic rd_dev;
    logic rd_dev_oe_b;
    logic wr_dev;
    logic wr_dev_oe_b;
    logic load_store_flag_b;
    logic load_store_flag_oe_b;
    logic flush_b;
    logic flush_oe_b;
    logic [7:0] we_b;
    logic [7:0] we_oe_b;
    logic exec_strobe;
    // resolved lines, undriven lines are pulled high
    logic [1:0] size_line;
    logic priv_line;
    logic rd_line;
    logic wr_line;
    logic load_store_flag_line;
    logic flush_line;
    logic [7:0] we_line;

    assign size_line = size_oe_b ? 2'h3 : size;
    assign priv_line = priv_oe_b | priv;
    assign rd_line = rd_dev_oe_b | rd_dev;
    assign wr_line = (wr_dev_oe_b | wr_dev) & (wr_cc_oe_b | wr_cc);
    assign load_store_flag_line = load_store_flag_oe_b | load_store_flag_b;
    assign flush_line = flush_oe_b | flush_b;
    assign we_line = we_oe_b | we_b;

    modport dev
    (
        input rd_grant_b, wr_grant_b, rd_ready_b, wr_ready_b, retry_b,
        input mem_exc_b, we_permit_b, test_b, wr_line,
        output size, size_oe_b, priv, priv_oe_b, rd_dev, rd_dev_oe_b,
        output wr_dev, wr_dev_oe_b, load_store_flag_b, load_store_flag_oe_b, flush_b, flush_oe_b,
        output we_b, we_oe_b, exec_strobe
    );

    modport cc
    (
        output rd_grant_b, wr_grant_b, rd_ready_b, wr_ready_b, retry_b,
        output mem_exc_b, we_permit_b, test_b, wr_cc, wr_cc_oe_b,
        input size_line, priv_line, rd_line, wr_line, load_store_flag_line,
        input flush_line, we_line, exec_strobe
    );
endinterface
`default_nettype wire

// ---- common/ccbp_pkg.sv ----
`default_nettype none
package ccbp_pkg;
    // transfer size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_DWORD = 2'h3;
    // byte lanes on the 64-bit data path
    localparam int BYTE_LANES = 8;
    // least reset hold once the clock is stable
    localparam int RESET_HOLD_CYC = 8;
    // idle cycles after an acknowledgment, covers the far end's synchroniser
    localparam int GAP_CYC = 3;
    localparam logic [1:0] GAP_LAST = 2'(GAP_CYC - 1);
    // controller default ready latency and invalidate quiet time
    localparam int ACK_LAT_CYC = 2;
    localparam int INV_HOLD_CYC = 3;
    // reset values of synchronised pin groups (pulled-up lines idle high)
    localparam logic [9:0] DEV_SYNC_RST = 10'h3FF;
    localparam logic [14:0] CC_SYNC_RST = 15'h7FFF;

    typedef enum logic [4:0]
    {
        KIND_READ = 5'h01,
        KIND_WRITE = 5'h02,
        KIND_SWAP = 5'h04,
        KIND_LOAD_STORE_FLAG = 5'h08,
        KIND_FLUSH = 5'h10
    } ccbp_kind_e;

    typedef enum logic [1:0]
    {
        ACK_NONE = 2'h0,
        ACK_OK = 2'h1,
        ACK_RETRY = 2'h2,
        ACK_ERROR = 2'h3
    } ccbp_ack_e;

    // a ready strobe carries the answer, retry and exception qualify it
    function automatic ccbp_ack_e ack_decode(input logic ready_b,
        input logic retry_b, input logic exc_b);
        if (ready_b)
            return ACK_NONE;
        else if (!exc_b)
            return ACK_ERROR;
        else if (!retry_b)
            return ACK_RETRY;
        else
            return ACK_OK;
    endfunction

    function automatic logic needs_read(input ccbp_kind_e k);
        return k != KIND_WRITE;
    endfunction

    function automatic logic needs_write(input ccbp_kind_e k);
        return k != KIND_READ;
    endfunction

    // big-endian lanes: bit 0 is the byte on data 63..56
    function automatic logic [7:0] lane_mask(input logic [1:0] size,
        input logic [2:0] addr);
        logic [7:0] m;
        int n;
        int start;
        m = 8'h00;
        n = 1 << size;
        start = int'(addr) & ~(n - 1);
        for (int i = 0; i < BYTE_LANES; i++)
            m[i] = (i >= start) && (i < start + n);
        return m;
    endfunction
endpackage
`default_nettype wire

// ---- rtl/ccbp_cc.sv ----
`timescale 1ns/10ps
`default_nettype none
module ccbp_cc
    import ccbp_pkg::*;
#(
    parameter int ACK_LAT = ACK_LAT_CYC
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // link toward the device
    ccbp_if.cc bus,
    // policy from the controller core
    input wire logic i_rd_grant,
    input wire logic i_wr_grant,
    input wire ccbp_pkg::ccbp_ack_e i_ack,
    input wire logic i_permit,
    input wire logic i_board_test,
    input wire logic i_inval,
    // observed transaction
    output logic o_seen,
    output ccbp_pkg::ccbp_kind_e o_kind,
    output logic [1:0] o_size,
    output logic o_user,
    output logic [7:0] o_we_mask
);
    import ccbp_pkg::*;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_WAIT = 5'h02,
        ST_ACK = 5'h04,
        ST_REL = 5'h08,
        ST_INV = 5'h10
    } ccbp_cc_st_e;

    ccbp_cc_st_e state;
    logic [14:0] pin_meta;
    logic [14:0] pin_sync;
    logic rd_s;
    logic wr_s;
    logic load_store_flag_s;
    logic flush_s;
    logic [1:0] size_s;
    logic priv_s;
    logic [7:0] we_s;
    logic [7:0] cnt;
    logic ack_strobe;

    // device pins are foreign to this clock
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pin_meta <= CC_SYNC_RST;
            pin_sync <= CC_SYNC_RST;
        end
        else
        begin
            pin_meta <= {bus.rd_line, bus.wr_line, bus.load_store_flag_line,
                bus.flush_line, bus.size_line, bus.priv_line, bus.we_line};
            pin_sync <= pin_meta;
        end
    end

    assign {rd_s, wr_s, load_store_flag_s, flush_s, size_s, priv_s, we_s} = pin_sync;

    // answer after a fixed latency, one strobe cycle, then wait release
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= ST_IDLE;
            cnt <= 8'h00;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    cnt <= 8'h00;
                    if (!rd_s || !wr_s)
                        state <= ST_WAIT;
                    else if (i_inval)
                        state <= ST_INV;
                end
                ST_WAIT:
                begin
                    cnt <= cnt + 8'h01;
                    if (cnt >= 8'(ACK_LAT - 1))
                        state <= ST_ACK;
                end
                ST_ACK:
                    state <= ST_REL;
                ST_REL:
                    if (rd_s && wr_s)
                        state <= ST_IDLE;
                ST_INV:
                begin
                    // own pulse must clear the synchroniser first
                    cnt <= cnt + 8'h01;
                    if (cnt >= 8'(INV_HOLD_CYC))
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // capture what the device presented
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_seen <= 1'b0;
            o_kind <= KIND_READ;
            o_size <= SIZE_BYTE;
            o_user <= 1'b0;
            o_we_mask <= 8'h00;
        end
        else
        begin
            o_seen <= state == ST_IDLE && (!rd_s || !wr_s);
            if (state == ST_IDLE)
            begin
                o_size <= size_s;
                o_user <= priv_s;
                if (!flush_s)
                    o_kind <= KIND_FLUSH;
                else if (!rd_s && !wr_s)
                    o_kind <= load_store_flag_s ? KIND_SWAP : KIND_LOAD_STORE_FLAG;
                else
                    o_kind <= rd_s ? KIND_WRITE : KIND_READ;
            end
            if (state == ST_WAIT || state == ST_ACK)
                o_we_mask <= o_we_mask | ~we_s;
            else if (state == ST_IDLE)
                o_we_mask <= 8'h00;
        end
    end

    // link outputs, registered
    assign ack_strobe = state == ST_ACK;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bus.rd_grant_b <= 1'b1;
            bus.wr_grant_b <= 1'b1;
            bus.rd_ready_b <= 1'b1;
            bus.wr_ready_b <= 1'b1;
            bus.retry_b <= 1'b1;
            bus.mem_exc_b <= 1'b1;
            bus.we_permit_b <= 1'b1;
            bus.test_b <= 1'b1;
            bus.wr_cc <= 1'b1;
            bus.wr_cc_oe_b <= 1'b1;
        end
        else
        begin
            bus.rd_grant_b <= !i_rd_grant;
            bus.wr_grant_b <= !i_wr_grant;
            // both ready lines strobe, as if tied together
            bus.rd_ready_b <= !(ack_strobe && i_ack != ACK_NONE);
            bus.wr_ready_b <= !(ack_strobe && i_ack != ACK_NONE);
            bus.retry_b <= !(ack_strobe && i_ack == ACK_RETRY);
            bus.mem_exc_b <= !(ack_strobe && i_ack == ACK_ERROR);
            bus.we_permit_b <= !i_permit;
            bus.test_b <= !i_board_test;
            bus.wr_cc <= !(state == ST_IDLE && rd_s && wr_s && i_inval);
            bus.wr_cc_oe_b <= !(state == ST_IDLE && rd_s && wr_s && i_inval);
        end
    end
endmodule // ccbp_cc
`default_nettype wire

// ---- rtl/ccbp_dev.sv ----
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - ready, retry and exception decode acknowledgment type
// - reads only while read grant low
// - read ready marks read data valid
// - drive size code for every transaction
// - privilege low supervisor, high user
// - board test low floats outputs except strobe
// - write enables driven only when asserted low
// - enable 0 is byte on bits 63..56
// - write enables driven only while permit low
// - write qualifier low; with read for swap/flush
// - write with read and load-store low is atomic
// - controller-driven write qualifier requests invalidation
// - write ready acknowledges data phase with retry/exception
// - writes only while write grant low
// - read qualifier low; with flush for flush cycles
// - reset may be held eight cycles when stable
// - mode select held low picks this port
module ccbp_dev
    import ccbp_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // link toward the cache controller
    ccbp_if.dev bus,
    // static mode strap, low selects this port
    input wire logic i_cc_select_b,
    // transaction request
    input wire logic i_req,
    input wire ccbp_pkg::ccbp_kind_e i_kind,
    input wire logic [1:0] i_size,
    input wire logic [2:0] i_addr_lo,
    input wire logic i_user,
    // breakpoint event for the execution strobe
    input wire logic i_break,
    // status and results
    output logic o_busy,
    output logic o_done,
    output ccbp_pkg::ccbp_ack_e o_ack,
    output logic o_rd_valid,
    output logic o_inval
);
    import ccbp_pkg::*;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_REQ = 4'h2,
        ST_DATA = 4'h4,
        ST_GAP = 4'h8
    } ccbp_dev_st_e;

    ccbp_dev_st_e state;
    ccbp_dev_st_e next_state;
    logic [9:0] pin_meta;
    logic [9:0] pin_sync;
    logic wr_line_d;
    logic rd_grant_s;
    logic wr_grant_s;
    logic rd_ready_s;
    logic wr_ready_s;
    logic retry_s;
    logic exc_s;
    logic permit_s;
    logic test_s;
    logic wr_line_s;
    logic sel_s;
    ccbp_kind_e kind;
    logic [1:0] size;
    logic [7:0] mask;
    logic user;
    logic nr;
    logic nw;
    logic granted;
    logic ready_b;
    ccbp_ack_e ack;
    logic [1:0] gap_cnt;
    logic qual_oe_b;
    logic [7:0] we_oe_b;

    // every pin input passes two flops before use
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pin_meta <= DEV_SYNC_RST;
            pin_sync <= DEV_SYNC_RST;
        end
        else
        begin
            pin_meta <= {bus.rd_grant_b, bus.wr_grant_b, bus.rd_ready_b,
                bus.wr_ready_b, bus.retry_b, bus.mem_exc_b,
                bus.we_permit_b, bus.test_b, bus.wr_line, i_cc_select_b};
            pin_sync <= pin_meta;
        end
    end

    assign {rd_grant_s, wr_grant_s, rd_ready_s, wr_ready_s, retry_s, exc_s,
        permit_s, test_s, wr_line_s, sel_s} = pin_sync;

    // grant and ready selection by what the transaction needs
    assign nr = needs_read(kind);
    assign nw = needs_write(kind);
    assign granted = (!nr || !rd_grant_s) && (!nw || !wr_grant_s);
    // a shared ready line works since either strobe answers
    assign ready_b = (!nr || rd_ready_s) && (!nw || wr_ready_s);
    assign ack = ack_decode(ready_b, retry_s, exc_s);

    // sequencer; a retry goes round again after the gap
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (i_req && !sel_s)
                    next_state = ST_REQ;
            ST_REQ:
                if (granted)
                    next_state = ST_DATA;
            ST_DATA:
                if (ack != ACK_NONE)
                    next_state = ST_GAP;
            ST_GAP:
                if (gap_cnt == GAP_LAST)
                    next_state = (o_ack == ACK_RETRY) ? ST_REQ : ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // gap lets the controller see the lines released
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            gap_cnt <= 2'h0;
        else if (state == ST_GAP)
            gap_cnt <= gap_cnt + 2'h1;
        else
            gap_cnt <= 2'h0;
    end

    // transaction is latched on acceptance and held across retries
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            kind <= KIND_READ;
            size <= SIZE_BYTE;
            mask <= 8'h00;
            user <= 1'b0;
        end
        else if (state == ST_IDLE && i_req && !sel_s)
        begin
            kind <= i_kind;
            size <= i_size;
            mask <= lane_mask(i_size, i_addr_lo);
            user <= i_user;
        end
    end

    // qualifier values, stable for the whole data phase
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bus.rd_dev <= 1'b1;
            bus.wr_dev <= 1'b1;
            bus.load_store_flag_b <= 1'b1;
            bus.flush_b <= 1'b1;
            bus.size <= SIZE_BYTE;
            bus.priv <= 1'b1;
            qual_oe_b <= 1'b1;
        end
        else if (next_state == ST_DATA && state == ST_REQ)
        begin
            bus.rd_dev <= !nr;
            bus.wr_dev <= !nw;
            bus.load_store_flag_b <= kind != KIND_LOAD_STORE_FLAG;
            bus.flush_b <= kind != KIND_FLUSH;
            bus.size <= size;
            bus.priv <= user;
            qual_oe_b <= 1'b0;
        end
        else if (next_state != ST_DATA)
        begin
            bus.rd_dev <= 1'b1;
            bus.wr_dev <= 1'b1;
            qual_oe_b <= 1'b1;
        end
    end

    // cache write enables, only for write kinds under the permit
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            we_oe_b <= 8'hFF;
        else if (state == ST_DATA && nw && !permit_s && ack == ACK_NONE)
            we_oe_b <= ~mask;
        else
            we_oe_b <= 8'hFF;
    end

    // board test overrides every enable, strobe excluded
    assign bus.size_oe_b = qual_oe_b || !test_s;
    assign bus.priv_oe_b = qual_oe_b || !test_s;
    assign bus.rd_dev_oe_b = qual_oe_b || !test_s;
    assign bus.wr_dev_oe_b = qual_oe_b || !test_s;
    assign bus.load_store_flag_oe_b = qual_oe_b || !test_s;
    assign bus.flush_oe_b = qual_oe_b || !test_s;
    assign bus.we_oe_b = we_oe_b | {8{!test_s}};
    assign bus.we_b = 8'h00;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            bus.exec_strobe <= 1'b0;
        else
            bus.exec_strobe <= i_break;
    end

    // result reporting
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_done <= 1'b0;
            o_ack <= ACK_NONE;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_done <= state == ST_DATA && ack != ACK_NONE;
            o_rd_valid <= state == ST_DATA && nr && ack == ACK_OK;
            if (state == ST_DATA && ack != ACK_NONE)
                o_ack <= ack;
        end
    end

    // invalidation: falling write line that this end is not driving
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_line_d <= 1'b1;
            o_inval <= 1'b0;
        end
        else
        begin
            wr_line_d <= wr_line_s;
            o_inval <= wr_line_d && !wr_line_s && state != ST_DATA;
        end
    end

    assign o_busy = state != ST_IDLE;
endmodule // ccbp_dev
`default_nettype wire

// ---- testbench/ccbp_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module ccbp_monitor
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // controller to device
    input wire logic rd_grant_b,
    input wire logic wr_grant_b,
    input wire logic rd_ready_b,
    input wire logic wr_ready_b,
    input wire logic we_permit_b,
    input wire logic test_b,
    // device to controller
    input wire logic [1:0] size,
    input wire logic size_oe_b,
    input wire logic priv,
    input wire logic rd_dev,
    input wire logic rd_dev_oe_b,
    input wire logic wr_dev,
    input wire logic wr_dev_oe_b,
    input wire logic load_store_flag_line,
    input wire logic flush_line,
    input wire logic [7:0] we_b,
    input wire logic [7:0] we_oe_b
);
    logic [3:0] since_ack;
    logic [3:0] qual;
    logic wr_drv;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    // rd, wr, load_store_flag, flush as the device asserts them, floating reads high
    assign qual = {rd_dev_oe_b | rd_dev, wr_dev_oe_b | wr_dev, load_store_flag_line,
        flush_line};
    assign wr_drv = !wr_dev_oe_b && !wr_dev;

    // cycles since a ready strobe, saturates so long idle cannot wrap
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            since_ack <= 4'hF;
        else if (!rd_ready_b || !wr_ready_b)
            since_ack <= 4'h0;
        else if (since_ack != 4'hF)
            since_ack <= since_ack + 4'h1;
    end

    // inputs pass two sync flops, so a level counts after four samples
    sequence test_held;
        !test_b [*4];
    endsequence
    sequence permit_off;
        we_permit_b [*4];
    endsequence
    sequence held_drive;
        !size_oe_b ##1 !size_oe_b;
    endsequence

    we_low_only_a: assert property (we_oe_b != 8'hFF |-> wr_drv &&
        (~we_oe_b & we_b) == 8'h00)
        else $error("write lane driven outside a low write");
    we_permit_a: assert property (permit_off |-> we_oe_b == 8'hFF)
        else $error("write lanes driven without permit");
    test_float_a: assert property (test_held |->
        &{size_oe_b, rd_dev_oe_b, wr_dev_oe_b, we_oe_b})
        else $error("outputs not floated in board test");
    we_lanes_a: assert property (!size_oe_b && we_oe_b != 8'hFF |->
        $countones(~we_oe_b) == (1 << size))
        else $error("write lane count differs from size");
    qual_code_a: assert property (!size_oe_b |->
        qual inside {4'h7, 4'hB, 4'h3, 4'h1, 4'h2})
        else $error("illegal qualifier combination");
    qual_stable_a: assert property (held_drive |->
        $stable(size) && $stable(priv) && $stable(qual))
        else $error("qualifiers changed before acknowledgment");
    qual_release_a: assert property ($rose(size_oe_b) && test_b |->
        since_ack inside {[1:5]})
        else $error("qualifiers released without acknowledgment");
    rd_grant_a: assert property ($fell(qual[3]) |->
        !$past(rd_grant_b) && !$past(rd_grant_b, 2))
        else $error("read issued without read grant");
    wr_grant_a: assert property ($rose(wr_drv) |->
        !$past(wr_grant_b) && !$past(wr_grant_b, 2))
        else $error("write issued without write grant");
endmodule // ccbp_monitor
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ccbp_pkg::*;
    localparam logic [7:0] WR_LANES [4] = '{8'h40, 8'hC0, 8'hF0, 8'hFF};
    localparam ccbp_kind_e KINDS [5] = '{KIND_READ, KIND_WRITE, KIND_SWAP,
        KIND_LOAD_STORE_FLAG, KIND_FLUSH};
    logic i_clk = 1'b0, i_rst_b = 1'b0, req = 1'b0, user = 1'b0, brk = 1'b0;
    logic permit = 1'b1, board_test = 1'b0, cc_inval = 1'b0;
    logic cc_sel_b = 1'b0;
    logic rd_grant = 1'b1, wr_grant = 1'b1;
    ccbp_kind_e kind = KIND_READ;
    ccbp_ack_e cc_ack = ACK_OK;
    logic [1:0] size = SIZE_BYTE;
    logic [2:0] addr_lo = 3'h0;
    logic busy, done, rd_valid, inval, cc_user;
    ccbp_ack_e ack;
    ccbp_kind_e cc_kind;
    logic [1:0] cc_size;
    logic [7:0] we_mask;
    int num_errors = 0;
    int comparisons = 0;

    ccbp_if bus();

    // device end and controller end face each other across the link
    ccbp_dev u_ccbp_dev
    (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus),
        .i_cc_select_b(cc_sel_b),
        .i_req(req), .i_kind(kind), .i_size(size), .i_addr_lo(addr_lo),
        .i_user(user), .i_break(brk), .o_busy(busy), .o_done(done),
        .o_ack(ack), .o_rd_valid(rd_valid), .o_inval(inval)
    );
    // a long answer delay leaves room to float the link mid-transfer
    ccbp_cc #(.ACK_LAT(12)) u_ccbp_cc
    (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus), .i_rd_grant(rd_grant),
        .i_wr_grant(wr_grant), .i_ack(cc_ack), .i_permit(permit),
        .i_board_test(board_test), .i_inval(cc_inval), .o_seen(),
        .o_kind(cc_kind), .o_size(cc_size), .o_user(cc_user),
        .o_we_mask(we_mask)
    );
    ccbp_monitor u_ccbp_monitor
    (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .rd_grant_b(bus.rd_grant_b),
        .wr_grant_b(bus.wr_grant_b), .rd_ready_b(bus.rd_ready_b),
        .wr_ready_b(bus.wr_ready_b), .we_permit_b(bus.we_permit_b),
        .test_b(bus.test_b), .size(bus.size), .size_oe_b(bus.size_oe_b),
        .priv(bus.priv), .rd_dev(bus.rd_dev), .rd_dev_oe_b(bus.rd_dev_oe_b),
        .wr_dev(bus.wr_dev), .wr_dev_oe_b(bus.wr_dev_oe_b),
        .load_store_flag_line(bus.load_store_flag_line), .flush_line(bus.flush_line),
        .we_b(bus.we_b), .we_oe_b(bus.we_oe_b)
    );

    // 200 MHz clock
    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // inputs move 1 ns after the edge so sampling never races
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim)
        begin
            step(1);
            n++;
        end
    endtask

    // one transfer from request to idle; a retry is answered once, then ok
    task automatic run(input ccbp_kind_e k, input logic [1:0] sz,
        input logic [2:0] a, input logic u, input ccbp_ack_e ans,
        input logic [7:0] mask);
        logic rv;
        ccbp_ack_e fin;
        fin = (ans == ACK_RETRY) ? ACK_OK : ans;
        cc_ack = ans;
        kind = k;
        size = sz;
        addr_lo = a;
        user = u;
        req = 1'b1;
        step(1);
        req = 1'b0;
        wait_for(bus.size_oe_b, 1'b0, 100);
        check(8'(bus.size_line), 8'(sz), "size on wire");
        check(8'(bus.priv_line), 8'(u), "privilege on wire");
        check(8'({bus.rd_line, bus.wr_line, bus.load_store_flag_line, bus.flush_line}),
            8'({k == KIND_WRITE, k == KIND_READ, k != KIND_LOAD_STORE_FLAG,
            k != KIND_FLUSH}), "qualifiers");
        wait_for(done, 1'b1, 200);
        if (ans == ACK_RETRY)
        begin
            check(8'(ack), 8'(ACK_RETRY), "retry code");
            cc_ack = ACK_OK;
            step(1);
            wait_for(done, 1'b1, 200);
        end
        check(8'(done), 8'h01, "no completion");
        rv = rd_valid;
        step(1);
        rv = rv | rd_valid;
        check(8'(ack), 8'(fin), "ack code");
        check(8'(rv), 8'(fin == ACK_OK && k != KIND_WRITE), "rd valid");
        check(8'({cc_kind, cc_size, cc_user}), 8'({k, sz, u}), "seen");
        if (k == KIND_WRITE)
            check(we_mask, mask, "write lanes");
        wait_for(busy, 1'b0, 50);
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(posedge i_clk);
        #1;
        i_rst_b = 1'b1;
        step(2);
        for (int i = 0; i < 4; i++)
            run(KIND_READ, 2'(i), 3'h0, i[0], ACK_OK, 8'h00);
        for (int i = 0; i < 4; i++)
            run(KIND_WRITE, 2'(i), 3'h6, !i[0], ACK_OK, WR_LANES[i]);
        for (int i = 0; i < 5; i++)
            run(KINDS[i], SIZE_DWORD, 3'h0, 1'b1, ACK_OK, 8'hFF);
        // permit withheld: the write completes with no lane driven
        permit = 1'b0;
        // the withdrawn permit needs the far end's synchroniser to settle
        step(4);
        run(KIND_WRITE, SIZE_WORD, 3'h0, 1'b0, ACK_OK, 8'h00);
        permit = 1'b1;
        for (int i = 0; i < 4; i++)
            run(i[0] ? KIND_WRITE : KIND_READ, SIZE_DWORD, 3'h0, 1'b0,
                i[1] ? ACK_ERROR : ACK_RETRY, 8'hFF);
        // grants held off for a while, then given
        for (int i = 0; i < 2; i++)
        begin
            rd_grant = 1'b0;
            wr_grant = 1'b0;
            // a withdrawn grant takes three edges to reach the device
            step(3);
            fork
                run(i ? KIND_WRITE : KIND_READ, SIZE_HALF, 3'h2, 1'b1,
                    ACK_OK, 8'h0C);
                begin
                    step(20);
                    check(8'({busy, bus.size_oe_b}), 8'h03,
                        "moved without grant");
                    rd_grant = 1'b1;
                    wr_grant = 1'b1;
                end
            join
        end
        // board test in mid-transfer, strobe must keep following
        fork
            run(KIND_SWAP, SIZE_DWORD, 3'h0, 1'b0, ACK_OK, 8'hFF);
            begin
                wait_for(bus.size_oe_b, 1'b0, 100);
                step(1);
                board_test = 1'b1;
                brk = 1'b1;
                step(6);
                check(8'({bus.size_oe_b, bus.rd_dev_oe_b, bus.wr_dev_oe_b,
                    &bus.we_oe_b, bus.exec_strobe}), 8'h1F, "float");
                board_test = 1'b0;
                brk = 1'b0;
            end
        join
        // strap high: a request is ignored, nothing moves
        cc_sel_b = 1'b1;
        step(3);
        req = 1'b1;
        step(3);
        check(8'({busy, bus.size_oe_b}), 8'h01, "strap");
        req = 1'b0;
        cc_sel_b = 1'b0;
        step(3);
        // invalidation request from the controller while idle
        step(4);
        cc_inval = 1'b1;
        step(1);
        cc_inval = 1'b0;
        wait_for(inval, 1'b1, 10);
        check(8'(inval), 8'h01, "no invalidate");
        summarize();
    end

    // some twenty transfers of about twenty-five cycles, with wide margin
    initial
    begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
endmodule // testbench
`default_nettype wire
